//--- src/fsd_duty_shaper.sv
`timescale 1ns/1ps
// Derives the pin duty and the read-back duty from the calculated duty
module fsd_duty_shaper (
    input wire logic [1:0] i_mode,
    input wire logic i_speed_sense_mode,
    input wire logic i_full_speed,
    input wire logic [7:0] i_calc_duty,
    output logic [7:0] o_pin_duty,
    output logic [7:0] o_read_duty
);
    typedef struct packed {
        logic [7:0] pin_duty;
        logic [7:0] read_duty;
    } fsd_shape_s;

    fsd_shape_s shape;

    always_comb begin
        shape.pin_duty = i_calc_duty;
        shape.read_duty = i_calc_duty;
        if (!i_speed_sense_mode) begin
            // R17 rpm mode floor
            if (i_mode == fsd_pkg::FSD_MODE_SW_RPM
                && fsd_pkg::fsd_below_pct(i_calc_duty, fsd_pkg::FSD_RPM_FLOOR_PCT)) begin
                shape.pin_duty = fsd_pkg::FSD_RPM_FLOOR_CODE;
            end
            // R18 low duty cutoff
            if ((i_mode == fsd_pkg::FSD_MODE_SW_DCY || i_mode == fsd_pkg::FSD_MODE_AUTO)
                && fsd_pkg::fsd_below_pct(i_calc_duty, fsd_pkg::FSD_OFF_FLOOR_PCT)) begin
                shape.pin_duty = fsd_pkg::FSD_DUTY_ZERO;
            end
        end
        // R1 full speed override
        if (i_full_speed) begin
            shape.pin_duty = fsd_pkg::FSD_DUTY_FULL;
            shape.read_duty = fsd_pkg::FSD_DUTY_FULL;
        end
    end

    assign o_pin_duty = shape.pin_duty;
    assign o_read_duty = shape.read_duty;
endmodule

//--- src/fsd_event_flag.sv
`timescale 1ns/1ps
// Status flag: sampled on an event, cleared on read, set wins over clear
module fsd_event_flag (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_sample,
    input wire logic i_cond,
    input wire logic i_clear,
    output logic o_flag
);
    typedef struct packed {
        logic flag;
    } fsd_flag_state_s;

    fsd_flag_state_s state_r;
    fsd_flag_state_s state_nxt;

    // Clear first, then a sample overrides it
    always_comb begin
        state_nxt = state_r;
        if (i_clear) begin
            state_nxt.flag = 1'b0;
        end
        if (i_sample) begin
            state_nxt.flag = i_cond;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_flag = state_r.flag;
endmodule

//--- src/fsd_pkg.sv
package fsd_pkg;

    // Register addresses
    localparam logic [7:0] FSD_ADDR_STATUS2 = 8'h03;
    localparam logic [7:0] FSD_ADDR_DUTY = 8'h22;

    // Reset values
    localparam logic [7:0] FSD_STATUS2_RESET = 8'h00;
    localparam logic [7:0] FSD_DUTY_RESET = 8'h55;

    // Second status register bit positions
    localparam int FSD_BIT_OVERHEAT_IN = 7;
    localparam int FSD_BIT_LOCAL_OVERHEAT = 6;
    localparam int FSD_BIT_PASSIVE = 5;
    localparam int FSD_BIT_LOCAL_CRIT = 4;
    localparam int FSD_BIT_REMOTE_CRIT = 3;

    // Duty scale and floors
    localparam logic [7:0] FSD_DUTY_FULL = 8'hFF;
    localparam logic [7:0] FSD_DUTY_ZERO = 8'h00;
    localparam int FSD_RPM_FLOOR_PCT = 30;
    localparam int FSD_OFF_FLOOR_PCT = 7;
    localparam logic [7:0] FSD_RPM_FLOOR_CODE = 8'((FSD_RPM_FLOOR_PCT * 255 + 99) / 100);

    // Overheat re-arm hysteresis in degrees
    localparam logic signed [8:0] FSD_OVERHEAT_HYST = 9'sh005;

    // Fan control modes, Gray ordered
    typedef enum logic [1:0] {
        FSD_MODE_AUTO = 2'b00,
        FSD_MODE_SW_RPM = 2'b01,
        FSD_MODE_SW_DCY = 2'b11
    } fsd_mode_e;

    // Monitoring results and limits, whole degrees, signed
    typedef struct packed {
        logic signed [7:0] local_temp;
        logic signed [7:0] remote_temp;
        logic signed [7:0] local_overheat_limit;
        logic signed [7:0] local_crit_temp;
        logic signed [7:0] remote_crit_temp;
        logic signed [7:0] control_temp;
        logic signed [7:0] passive_cooling_temp;
    } fsd_temps_s;

    // Register access request from the serial interface engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fsd_reg_req_s;

    // True when duty code lies strictly below a percentage of full scale
    function automatic logic fsd_below_pct(input logic [7:0] code, input int pct);
        logic [15:0] lhs;
        logic [15:0] rhs;
        lhs = 16'(code) * 16'd100;
        rhs = 16'(pct * 255);
        return lhs < rhs;
    endfunction

endpackage

//--- src/fsd_status_duty.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Overheat pin pulled low externally sets status bit 7 and forces full fan speed.
// R2 - Overheat input flag clears on status two read, resets while pin stays low.
// R3 - Bit 6 set when local temperature exceeds overheat limit; overheat pin driven low.
// R4 - Local overheat flag raises alert only with overheat interrupt enable set.
// R5 - Bit 6 clears on status one read, re-arms after dropping five degrees below limit.
// R6 - Bit 5 set when control temperature at or below passive cooling temperature.
// R7 - Passive flag alerts when enabled, clears on read, reasserts next monitoring cycle.
// R8 - Bit 4 set at local critical; drives over-temperature pin low, unmaskable alert.
// R9 - Local critical flag clears on status two read, resets next monitoring cycle.
// R10 - Bit 3 set at remote critical; drives over-temperature pin low, unmaskable alert.
// R11 - Remote critical flag clears on status two read, resets next monitoring cycle.
// R12 - Status two bits 2 to 0 always read zero.
// R13 - Status two register reads all zeros after reset.
// R14 - Duty code maps linearly onto PWM duty, zero to full scale.
// R15 - Duty register resets to 0x55.
// R16 - Duty reads return the duty driving the pin, except two low-duty cases.
// R17 - Speed sense zero, rpm mode: below 30 percent pin forced to 30 percent.
// R18 - Speed sense zero, duty or auto mode: below 7 percent pin forced off.
// R19 - In software duty mode a written duty drives the PWM directly.
// R20 - In other modes a written duty is held, applied on entering duty mode.
// R21 - Writes to status two are ignored.
module fsd_status_duty (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire fsd_pkg::fsd_reg_req_s i_reg_req,
    output logic [7:0] o_reg_rdata,
    input wire logic i_status1_read,
    input wire logic i_monitor_tick,
    input wire fsd_pkg::fsd_temps_s i_temps,
    input wire logic [1:0] i_ctrl_mode,
    input wire logic i_speed_sense_mode,
    input wire logic [7:0] i_loop_duty,
    input wire logic i_overheat_irq_enable,
    input wire logic i_passive_irq_enable,
    input wire logic i_overheat_pin_in,
    output logic o_overheat_pin_out,
    output logic o_overheat_pin_oe,
    output logic o_overtemp_alert_pin_n,
    output logic o_smbalert_n,
    output logic [7:0] o_pwm_duty,
    output logic o_full_speed
);
    typedef struct packed {
        logic local_overheat_flag;
        logic overheat_rearm_wait;
        logic [7:0] duty_value;
        logic [7:0] rdata;
        logic overheat_oe;
        logic overtemp_n;
        logic alert_n;
        logic [7:0] pwm_duty;
        logic full_speed;
    } fsd_state_s;

    fsd_state_s state_r;
    fsd_state_s state_nxt;

    logic status2_rd;
    logic duty_wr;
    logic pin_pulled_low;
    logic overheat_input_flag;
    logic passive_cooling_flag;
    logic local_critical_flag;
    logic remote_critical_flag;
    logic local_over_cond;
    logic local_rearm_cond;
    logic [7:0] calc_duty;
    logic [7:0] pin_duty;
    logic [7:0] read_duty;
    logic [7:0] status2_value;

    // Register decode
    assign status2_rd = i_reg_req.rd && i_reg_req.addr == fsd_pkg::FSD_ADDR_STATUS2;
    assign duty_wr = i_reg_req.wr && i_reg_req.addr == fsd_pkg::FSD_ADDR_DUTY;

    // R1 external pull-low seen only while not driving the pin
    assign pin_pulled_low = !i_overheat_pin_in && !state_r.overheat_oe;

    // Local overheat compare and re-arm threshold
    assign local_over_cond = i_temps.local_temp > i_temps.local_overheat_limit;
    assign local_rearm_cond = 9'(i_temps.local_temp)
        <= 9'(i_temps.local_overheat_limit) - fsd_pkg::FSD_OVERHEAT_HYST;

    // R1 R2 overheat input flag
    fsd_event_flag u_overheat_in (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_sample(pin_pulled_low),
        .i_cond(1'b1),
        .i_clear(status2_rd),
        .o_flag(overheat_input_flag)
    );

    // R6 R7 passive cooling flag
    fsd_event_flag u_passive (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_sample(i_monitor_tick),
        .i_cond(i_temps.control_temp <= i_temps.passive_cooling_temp),
        .i_clear(status2_rd),
        .o_flag(passive_cooling_flag)
    );

    // R8 R9 local critical flag
    fsd_event_flag u_local_crit (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_sample(i_monitor_tick),
        .i_cond(i_temps.local_temp >= i_temps.local_crit_temp),
        .i_clear(status2_rd),
        .o_flag(local_critical_flag)
    );

    // R10 R11 remote critical flag
    fsd_event_flag u_remote_crit (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_sample(i_monitor_tick),
        .i_cond(i_temps.remote_temp >= i_temps.remote_crit_temp),
        .i_clear(status2_rd),
        .o_flag(remote_critical_flag)
    );

    // R12 reserved bits zero
    always_comb begin
        status2_value = fsd_pkg::FSD_STATUS2_RESET;
        status2_value[fsd_pkg::FSD_BIT_OVERHEAT_IN] = overheat_input_flag;
        status2_value[fsd_pkg::FSD_BIT_LOCAL_OVERHEAT] = state_r.local_overheat_flag;
        status2_value[fsd_pkg::FSD_BIT_PASSIVE] = passive_cooling_flag;
        status2_value[fsd_pkg::FSD_BIT_LOCAL_CRIT] = local_critical_flag;
        status2_value[fsd_pkg::FSD_BIT_REMOTE_CRIT] = remote_critical_flag;
    end

    // R19 R20 duty source by mode
    assign calc_duty = (i_ctrl_mode == fsd_pkg::FSD_MODE_SW_DCY) ? state_r.duty_value : i_loop_duty;

    // R14 R16 pin and read-back duty
    fsd_duty_shaper u_shaper (
        .i_mode(i_ctrl_mode),
        .i_speed_sense_mode(i_speed_sense_mode),
        .i_full_speed(overheat_input_flag),
        .i_calc_duty(calc_duty),
        .o_pin_duty(pin_duty),
        .o_read_duty(read_duty)
    );

    // Next state
    always_comb begin
        state_nxt = state_r;

        // R5 clear on status one read, then wait for re-arm
        if (i_status1_read && state_r.local_overheat_flag) begin
            state_nxt.local_overheat_flag = 1'b0;
            state_nxt.overheat_rearm_wait = 1'b1;
        end
        // R3 monitoring result, set wins over clear
        if (i_monitor_tick) begin
            if (state_r.overheat_rearm_wait) begin
                state_nxt.local_overheat_flag = 1'b0;
                if (local_rearm_cond) begin
                    state_nxt.overheat_rearm_wait = 1'b0;
                end
            end else begin
                state_nxt.local_overheat_flag = local_over_cond;
                if (local_over_cond) begin
                    state_nxt.overheat_rearm_wait = 1'b0;
                end
            end
        end

        // R19 R20 duty write, held while not in duty mode
        if (duty_wr) begin
            state_nxt.duty_value = i_reg_req.wdata;
        end

        // R21 status writes fall through unused
        case (i_reg_req.addr)
            fsd_pkg::FSD_ADDR_STATUS2: state_nxt.rdata = status2_value;
            fsd_pkg::FSD_ADDR_DUTY: state_nxt.rdata = read_duty;
            default: state_nxt.rdata = 8'h00;
        endcase
        if (!i_reg_req.rd) begin
            state_nxt.rdata = state_r.rdata;
        end

        // R3 overheat pin low while flag set
        state_nxt.overheat_oe = state_nxt.local_overheat_flag;
        // R8 R10 over-temperature pin
        state_nxt.overtemp_n = !(local_critical_flag || remote_critical_flag);
        // R4 R7 R8 R10 alert sources
        state_nxt.alert_n = !((state_r.local_overheat_flag && i_overheat_irq_enable)
            || (passive_cooling_flag && i_passive_irq_enable)
            || local_critical_flag || remote_critical_flag);
        // R17 R18 R1 shaped pin duty
        state_nxt.pwm_duty = pin_duty;
        state_nxt.full_speed = overheat_input_flag;
    end

    // R13 R15 reset values
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r.local_overheat_flag <= 1'b0;
            state_r.overheat_rearm_wait <= 1'b0;
            state_r.duty_value <= fsd_pkg::FSD_DUTY_RESET;
            state_r.rdata <= 8'h00;
            state_r.overheat_oe <= 1'b0;
            state_r.overtemp_n <= 1'b1;
            state_r.alert_n <= 1'b1;
            state_r.pwm_duty <= fsd_pkg::FSD_DUTY_RESET;
            state_r.full_speed <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from flops, overheat pin data tied low
    assign o_reg_rdata = state_r.rdata;
    assign o_overheat_pin_out = 1'b0;
    assign o_overheat_pin_oe = state_r.overheat_oe;
    assign o_overtemp_alert_pin_n = state_r.overtemp_n;
    assign o_smbalert_n = state_r.alert_n;
    assign o_pwm_duty = state_r.pwm_duty;
    assign o_full_speed = state_r.full_speed;
endmodule

//--- testbench/fan_status_and_duty_regs_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module fan_status_and_duty_regs_test;
    logic clk = 1'h0, rst = 1'h1, tick = 1'h0, s1rd = 1'h0, ext_n = 1'h1;
    logic oh_en = 1'h0, ps_en = 1'h0, pout, oe, ovr_n, alert_n, full;
    logic sense = 1'h0;
    logic [1:0] mode = 2'h3;
    logic [7:0] loop = 8'h00, rdata, pwm;
    int n_fail = 0, checked = 0;
    fsd_pkg::fsd_reg_req_s req;
    fsd_pkg::fsd_temps_s tp = '{8'h14, 8'h14, 8'h3C, 8'h50, 8'h50, 8'h1E, 8'h0A};
    // Open drain wire: external pull or device pull
    wire pin = ext_n & ~oe;
    always #25 clk = ~clk;
    fsd_host host (.i_clk_sys(clk), .i_rdata(rdata), .o_req(req));
    fsd_status_duty DUT (.i_clk_sys(clk), .i_reset(rst), .i_reg_req(req), .o_reg_rdata(rdata),
        .i_status1_read(s1rd), .i_monitor_tick(tick), .i_temps(tp), .i_ctrl_mode(mode),
        .i_speed_sense_mode(sense), .i_loop_duty(loop), .i_overheat_irq_enable(oh_en),
        .i_passive_irq_enable(ps_en), .i_overheat_pin_in(pin), .o_overheat_pin_out(pout),
        .o_overheat_pin_oe(oe), .o_overtemp_alert_pin_n(ovr_n), .o_smbalert_n(alert_n),
        .o_pwm_duty(pwm), .o_full_speed(full));
    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        `CHK(n, e, d)
    endtask
    task automatic wt();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic tk();
        @(posedge clk) tick <= 1'h1;
        @(posedge clk) tick <= 1'h0;
        wt();
    endtask
    task automatic pulse_s1();
        @(posedge clk) s1rd <= 1'h1;
        @(posedge clk) s1rd <= 1'h0;
    endtask
    task automatic t_reset();
        rdc("st2", 8'h03, 8'h00);
        rdc("duty", 8'h22, 8'h55);
        `CHK("pwm", 8'h55, pwm)
        host.wr(8'h03, 8'hFF);
        rdc("st2 wr", 8'h03, 8'h00);
        rdc("unmap", 8'h40, 8'h00);
    endtask
    task automatic t_duty();
        host.wr(8'h22, 8'h80);
        wt();
        `CHK("pwm", 8'h80, pwm)
        rdc("duty", 8'h22, 8'h80);
        host.wr(8'h22, 8'h10);
        wt();
        `CHK("pwm off", 8'h00, pwm)
        rdc("duty off", 8'h22, 8'h10);
        @(posedge clk) begin mode <= 2'h0; loop <= 8'hC0; end
        host.wr(8'h22, 8'h40);
        wt();
        `CHK("pwm auto", 8'hC0, pwm)
        rdc("duty auto", 8'h22, 8'hC0);
        @(posedge clk) mode <= 2'h3;
        wt();
        `CHK("pwm held", 8'h40, pwm)
        @(posedge clk) begin mode <= 2'h1; loop <= 8'h20; end
        wt();
        `CHK("pwm rpm", 8'h4D, pwm)
        rdc("duty rpm", 8'h22, 8'h20);
        // Speed sense set: no floor, pin follows the calculated duty
        @(posedge clk) sense <= 1'h1;
        wt();
        `CHK("pwm sense", 8'h20, pwm)
        @(posedge clk) begin sense <= 1'h0; mode <= 2'h3; end
    endtask
    task automatic t_flags();
        @(posedge clk) begin tp.local_temp <= 8'h55; tp.remote_temp <= 8'h5A; tp.control_temp <= 8'h05; end
        tk();
        `CHK("ovr", 1'h0, ovr_n)
        `CHK("oe", 1'h1, oe)
        `CHK("alert", 1'h0, alert_n)
        rdc("st2 set", 8'h03, 8'h78);
        rdc("st2 clr", 8'h03, 8'h40);
        pulse_s1();
        tk();
        rdc("st2 wait", 8'h03, 8'h38);
        @(posedge clk) begin tp.local_temp <= 8'h32; tp.remote_temp <= 8'h14; tp.control_temp <= 8'h1E; end
        tk();
        rdc("st2 rearm", 8'h03, 8'h00);
        @(posedge clk) tp.local_temp <= 8'h46;
        tk();
        rdc("st2 again", 8'h03, 8'h40);
        `CHK("alert off", 1'h1, alert_n)
        @(posedge clk) oh_en <= 1'h1;
        wt();
        `CHK("alert on", 1'h0, alert_n)
        @(posedge clk) oh_en <= 1'h0;
        pulse_s1();
        wt();
        `CHK("oe off", 1'h0, oe)
    endtask
    task automatic t_pin();
        @(posedge clk) ext_n <= 1'h0;
        wt();
        `CHK("full", 1'h1, full)
        `CHK("pwm full", 8'hFF, pwm)
        rdc("st2 pin", 8'h03, 8'h80);
        rdc("st2 held", 8'h03, 8'h80);
        rdc("duty full", 8'h22, 8'hFF);
        @(posedge clk) ext_n <= 1'h1;
        wt();
        rdc("st2 last", 8'h03, 8'h80);
        rdc("st2 free", 8'h03, 8'h00);
        `CHK("full off", 1'h0, full)
        // Passive cooling alert gated by its enable
        @(posedge clk) tp.control_temp <= 8'h05;
        tk();
        `CHK("psv masked", 1'h1, alert_n)
        @(posedge clk) ps_en <= 1'h1;
        wt();
        `CHK("psv alert", 1'h0, alert_n)
        rdc("st2 psv", 8'h03, 8'h20);
        @(posedge clk) ps_en <= 1'h0;
    endtask
    task automatic end_sim();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog well past the expected run
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_duty();
        t_flags();
        t_pin();
        end_sim();
    end
endmodule
bind fsd_status_duty fsd_monitor mon (.i_clk_sys, .i_reset, .i_reg_req, .o_reg_rdata, .i_monitor_tick,
    .i_overheat_pin_in, .o_overheat_pin_out, .o_overheat_pin_oe, .o_overtemp_alert_pin_n, .o_pwm_duty,
    .o_full_speed);

//--- testbench/fsd_host.sv
`timescale 1ns/1ps
// Bus host issuing single byte register cycles
module fsd_host (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rdata,
    output fsd_pkg::fsd_reg_req_s o_req
);
    initial o_req = '0;
    // Write, then scramble the released fields
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys) o_req <= '{1'h0, 1'h1, a, d};
        @(posedge i_clk_sys) o_req <= '{1'h0, 1'h0, ~a, ~d};
    endtask
    // Read, data taken once it has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys) o_req <= '{1'h1, 1'h0, a, 8'h00};
        @(posedge i_clk_sys) o_req <= '{1'h0, 1'h0, ~a, 8'hFF};
        @(posedge i_clk_sys) #1 d = i_rdata;
    endtask
endmodule

//--- testbench/fsd_monitor.sv
`timescale 1ns/1ps
// Port checker for the status and duty block
module fsd_monitor (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire fsd_pkg::fsd_reg_req_s i_reg_req,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_monitor_tick,
    input wire logic i_overheat_pin_in,
    input wire logic o_overheat_pin_out,
    input wire logic o_overheat_pin_oe,
    input wire logic o_overtemp_alert_pin_n,
    input wire logic [7:0] o_pwm_duty,
    input wire logic o_full_speed
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // Read of status two, read of an unmapped place
    sequence s_rd3;
        i_reg_req.rd && i_reg_req.addr == 8'h03;
    endsequence
    sequence s_rdx;
        i_reg_req.rd && i_reg_req.addr != 8'h03 && i_reg_req.addr != 8'h22;
    endsequence
    property p_odrain;
        o_overheat_pin_out == 1'h0;
    endproperty
    a_odrain: assert property (p_odrain) else $error("overheat pin driven high");
    property p_resv;
        s_rd3 |=> o_reg_rdata[2:0] == 3'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    property p_unmap;
        s_rdx |=> o_reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold;
        !i_reg_req.rd |=> $stable(o_reg_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_sense;
        !i_overheat_pin_in && !o_overheat_pin_oe |-> ##[1:2] o_full_speed;
    endproperty
    a_sense: assert property (p_sense) else $error("pulled pin not seen");
    property p_full;
        o_full_speed && $past(o_full_speed) |-> o_pwm_duty == 8'hFF;
    endproperty
    a_full: assert property (p_full) else $error("full speed not applied");
    property p_ovr;
        $fell(o_overtemp_alert_pin_n) |-> $past(i_monitor_tick) || $past(i_monitor_tick, 2);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overtemp pin without tick");
    property p_oe;
        $rose(o_overheat_pin_oe) |-> $past(i_monitor_tick) || $past(i_monitor_tick, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("overheat pin without tick");
endmodule
